// ==== rtl/radio_task_event_regs.sv ====
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "radio_task_event_map.svh"
module radio_task_event_regs
	import radio_task_event_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ev_ramp_done,
	input wire logic ev_address_seen,
	input wire logic ev_payload_done,
	input wire logic ev_packet_end,
	input wire logic ev_radio_off,
	input wire logic ev_device_hit,
	input wire logic ev_device_miss,
	input wire logic ev_strength_done,
	input wire logic ev_bit_count_hit,
	input wire logic ev_checksum_good,
	input wire logic ev_checksum_bad,
	input wire logic ev_frame_length,
	output logic cca_begin_pulse,
	output logic cca_halt_pulse
);

	// ************************************************************
	// Address decode
	// ************************************************************

	// Maps a word address onto a flag index, a trigger slot or none.
	// The two low address bits are ignored, so an unaligned address aliases its word.
	function automatic slot_t slot_of(input logic [ADDR_W-1:0] a);
		logic [11:0] w;
		w = {a[11:2], 2'b00};
		case (w)
			`OFS_RAMP_DONE: slot_of = 5'h00; // [R03]
			`OFS_ADDRESS_SEEN: slot_of = 5'h01; // [R04]
			`OFS_PAYLOAD_DONE: slot_of = 5'h02; // [R05]
			`OFS_PACKET_END: slot_of = 5'h03; // [R06]
			`OFS_RADIO_OFF: slot_of = 5'h04; // [R07]
			`OFS_DEVICE_HIT: slot_of = 5'h05; // [R08]
			`OFS_DEVICE_MISS: slot_of = 5'h06; // [R09]
			`OFS_STRENGTH_DONE: slot_of = 5'h07; // [R10]
			`OFS_BIT_COUNT_HIT: slot_of = 5'h08; // [R11]
			`OFS_CHECKSUM_GOOD: slot_of = 5'h09; // [R12]
			`OFS_CHECKSUM_BAD: slot_of = 5'h0A; // [R13]
			`OFS_FRAME_LENGTH: slot_of = 5'h0B; // [R14]
			`OFS_CCA_BEGIN: slot_of = `SLOT_BEGIN; // [R01]
			`OFS_CCA_HALT: slot_of = `SLOT_HALT; // [R02]
			default: slot_of = `SLOT_NONE;
		endcase
	endfunction

	// ************************************************************
	// Write channel
	// ************************************************************

	wr_state_t wr_state_q;
	logic wr_fire;
	slot_t wr_slot;
	logic [1:0] bresp_q;
	logic [`NUM_FLAGS-1:0] clear_mask;
	logic [1:0] trig_fire;
	logic [`NUM_FLAGS-1:0] ev_vec;
	logic [`NUM_FLAGS-1:0] flags_q;
	logic [1:0] pulse_vec;

	// Address and data are taken together; this keeps one write in flight
	// and avoids holding registers for a lone address or lone data beat.
	assign awready = ce && (wr_state_q == WR_IDLE) && awvalid && wvalid;
	assign wready = awready;
	assign wr_fire = awready;
	assign wr_slot = slot_of(awaddr);
	assign bvalid = (wr_state_q == WR_RESP);
	assign bresp = bresp_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			wr_state_q <= WR_IDLE;
		else if (ce)
		begin
			case (wr_state_q)
				WR_IDLE:
					if (wr_fire)
						wr_state_q <= WR_RESP;
				WR_RESP:
					if (bready)
						wr_state_q <= WR_IDLE;
				default:
					wr_state_q <= WR_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp_q <= `RESP_OKAY;
		else if (ce && wr_fire)
			bresp_q <= (wr_slot == `SLOT_NONE) ? `RESP_SLVERR : `RESP_OKAY;
	end

	// Writing 0 into bit 0 of a flag clears it; writing 1 is ignored.
	always_comb
	begin
		clear_mask = '0;
		if (wr_fire && wstrb[0] && !wdata[0] && wr_slot < 5'(`NUM_FLAGS))
			clear_mask[wr_slot[3:0]] = 1'b1; // [R15]
	end

	// Triggers fire only on a written 1; a written 0 does nothing.
	always_comb
	begin
		trig_fire = 2'b00;
		if (wr_fire && wstrb[0] && wdata[`TRIGGER_BIT])
		begin
			trig_fire[0] = (wr_slot == `SLOT_BEGIN); // [R01]
			trig_fire[1] = (wr_slot == `SLOT_HALT); // [R02]
		end
	end

	task_strobe #(
		.N(2)
	) task_strobe_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.fire(trig_fire),
		.pulse_q(pulse_vec)
	);

	// Bit 0 carries the begin trigger and bit 1 the halt trigger.
	assign cca_begin_pulse = pulse_vec[0]; // [R01]
	assign cca_halt_pulse = pulse_vec[1]; // [R02]

	// ************************************************************
	// Event flags
	// ************************************************************

	// Events are taken only while the enable is high; a pulse during a freeze is lost.
	assign ev_vec = {ev_frame_length, ev_checksum_bad, ev_checksum_good, ev_bit_count_hit,
		ev_strength_done, ev_device_miss, ev_device_hit, ev_radio_off,
		ev_packet_end, ev_payload_done, ev_address_seen, ev_ramp_done};

	event_flag_bank #(
		.N(`NUM_FLAGS)
	) event_flag_bank_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.set_pulse(ev_vec),
		.clear_mask(clear_mask),
		.flags_q(flags_q)
	);

	// ************************************************************
	// Read channel
	// ************************************************************

	rd_state_t rd_state_q;
	slot_t rd_slot;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	assign arready = ce && (rd_state_q == RD_IDLE);
	assign rvalid = (rd_state_q == RD_DATA);
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign rd_slot = slot_of(araddr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rd_state_q <= RD_IDLE;
		else if (ce)
		begin
			case (rd_state_q)
				RD_IDLE:
					if (arvalid)
						rd_state_q <= RD_DATA;
				RD_DATA:
					if (rready)
						rd_state_q <= RD_IDLE;
				default:
					rd_state_q <= RD_IDLE;
			endcase
		end
	end

	// Triggers read as zero; unmapped words read zero with an error.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
		end
		else if (arready && arvalid)
		begin
			rdata_q <= 32'h00000000;
			rresp_q <= `RESP_OKAY;
			if (rd_slot < 5'(`NUM_FLAGS))
				rdata_q[0] <= flags_q[rd_slot[3:0]];
			else if (rd_slot == `SLOT_NONE)
				rresp_q <= `RESP_SLVERR;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************

	property p_set(ev, fl);
		@(posedge aclk) disable iff (!aresetn) (ce && ev) |=> fl;
	endproperty

	a_begin_strobe: // [R01]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && awaddr == `OFS_CCA_BEGIN && wstrb[0] && wdata[0]) |=> cca_begin_pulse)
	else $error("begin trigger write gave no pulse");

	a_halt_strobe: // [R02]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(cca_halt_pulse && ce) |=> !cca_halt_pulse || $past(trig_fire[1]))
	else $error("halt pulse stretched without a write");

	a_halt_cause: // [R02]
	assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cca_halt_pulse) |-> $past(wr_fire) && $past(awaddr) == `OFS_CCA_HALT)
	else $error("halt pulse without halt write");

	a_ramp_set: // [R03]
	assert property (p_set(ev_ramp_done, flags_q[0])) else $error("ramp flag not set");
	a_address_set: // [R04]
	assert property (p_set(ev_address_seen, flags_q[1])) else $error("address flag not set");
	a_payload_set: // [R05]
	assert property (p_set(ev_payload_done, flags_q[2])) else $error("payload flag not set");
	a_end_set: // [R06]
	assert property (p_set(ev_packet_end, flags_q[3])) else $error("end flag not set");
	a_off_set: // [R07]
	assert property (p_set(ev_radio_off, flags_q[4])) else $error("off flag not set");
	a_hit_set: // [R08]
	assert property (p_set(ev_device_hit, flags_q[5])) else $error("hit flag not set");
	a_miss_set: // [R09]
	assert property (p_set(ev_device_miss, flags_q[6])) else $error("miss flag not set");
	a_strength_set: // [R10]
	assert property (p_set(ev_strength_done, flags_q[7])) else $error("strength flag not set");
	a_count_set: // [R11]
	assert property (p_set(ev_bit_count_hit, flags_q[8])) else $error("count flag not set");
	a_good_set: // [R12]
	assert property (p_set(ev_checksum_good, flags_q[9])) else $error("good flag not set");
	a_bad_set: // [R13]
	assert property (p_set(ev_checksum_bad, flags_q[10])) else $error("bad flag not set");
	a_frame_set: // [R14]
	assert property (p_set(ev_frame_length, flags_q[11])) else $error("frame flag not set");

	a_flag_holds: // [R15]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(flags_q[3] && !clear_mask[3]) |=> flags_q[3])
	else $error("end flag dropped without a clear");

	a_clear_effect: // [R15]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && clear_mask[0] && !ev_vec[0]) |=> !flags_q[0])
	else $error("ramp flag survived a clear");

	a_read_flag: // [R11]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(arready && arvalid && araddr == `OFS_BIT_COUNT_HIT) |=> rvalid && rdata == {31'h0, $past(flags_q[8])})
	else $error("bit count flag read wrong");

	a_begin_single: // [R01]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(cca_begin_pulse && ce) |=> !cca_begin_pulse || $past(trig_fire[0]))
	else $error("begin pulse stretched without a write");

	a_begin_cause: // [R01]
	assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cca_begin_pulse) |-> $past(wr_fire) && $past(awaddr) == `OFS_CCA_BEGIN && $past(wdata[0]))
	else $error("begin pulse without begin write");

	a_zero_ignored: // [R01]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && awaddr == `OFS_CCA_BEGIN && !wdata[0]) |=> !cca_begin_pulse)
	else $error("begin pulse after a written zero");

	a_halt_fires: // [R02]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(wr_fire && awaddr == `OFS_CCA_HALT && wstrb[0] && wdata[0]) |=> cca_halt_pulse)
	else $error("halt trigger write gave no pulse");

	a_trigger_reads_zero: // [R02]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(arready && arvalid && araddr == `OFS_CCA_HALT) |=> rvalid && rdata == 32'h00000000)
	else $error("halt trigger read not zero");

	a_set_wins: // [R15]
	assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && clear_mask[3] && ev_vec[3]) |=> flags_q[3])
	else $error("clear beat a coinciding event");

	// Reset is not gated by the enable, so this check carries no disable clause.
	a_reset_state: // [R03]
	assert property (@(posedge aclk)
		!aresetn |=> flags_q == `FLAG_RESET && !cca_begin_pulse && !cca_halt_pulse && !bvalid && !rvalid)
	else $error("state not cleared by reset");

	// A low enable must hold every flag and strobe where it stands.
	a_enable_freeze:
	assert property (@(posedge aclk) disable iff (!aresetn)
		(!ce && aresetn) |=> $stable(flags_q) && $stable(cca_begin_pulse) && $stable(cca_halt_pulse))
	else $error("state moved while the enable was low");

	a_write_answer:
	assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> bvalid)
	else $error("write got no response");

	c_begin_write: cover property (@(posedge aclk) disable iff (!aresetn) cca_begin_pulse);
	c_clear_race: cover property (@(posedge aclk) disable iff (!aresetn) ce && clear_mask[3] && ev_vec[3]);
	c_flag_read: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready && rdata[0]);
	c_bad_addr: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bresp == `RESP_SLVERR);
	c_frozen_event: cover property (@(posedge aclk) disable iff (!aresetn) !ce && ev_vec[2]);

endmodule

// ==== rtl/radio_task_event_map.svh ====
// Behaviour
// (R01) Writing 1 at 0x02C starts channel assessment.
// (R02) Writing 1 at 0x030 halts channel assessment.
// (R03) Ramp-done flag at 0x100 sets on ramp.
// (R04) Address flag at 0x104 sets on address.
// (R05) Payload flag at 0x108 sets on payload.
// (R06) Packet-end flag at 0x10C sets on end.
// (R07) Disabled flag at 0x110 sets on disable.
// (R08) Device-hit flag at 0x114 sets on match.
// (R09) Device-miss flag at 0x118 sets on miss.
// (R10) Strength-done flag at 0x11C sets on sample.
// (R11) Bit-count flag at 0x128 sets on match.
// (R12) Checksum-good flag at 0x130 sets on pass.
// (R13) Checksum-bad flag at 0x134 sets on fail.
// (R14) Frame-length flag at 0x138 sets on length.
// (R15) Flags hold until cleared; set beats clear.
`ifndef RADIO_TASK_EVENT_MAP_SVH
`define RADIO_TASK_EVENT_MAP_SVH

`define OFS_CCA_BEGIN 12'h02C
`define OFS_CCA_HALT 12'h030
`define OFS_RAMP_DONE 12'h100
`define OFS_ADDRESS_SEEN 12'h104
`define OFS_PAYLOAD_DONE 12'h108
`define OFS_PACKET_END 12'h10C
`define OFS_RADIO_OFF 12'h110
`define OFS_DEVICE_HIT 12'h114
`define OFS_DEVICE_MISS 12'h118
`define OFS_STRENGTH_DONE 12'h11C
`define OFS_BIT_COUNT_HIT 12'h128
`define OFS_CHECKSUM_GOOD 12'h130
`define OFS_CHECKSUM_BAD 12'h134
`define OFS_FRAME_LENGTH 12'h138

`define NUM_FLAGS 12
`define SLOT_BEGIN 5'h0C
`define SLOT_HALT 5'h0D
`define SLOT_NONE 5'h1F
`define FLAG_RESET 12'h000
`define TRIGGER_BIT 0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== rtl/radio_task_event_pkg.sv ====
package radio_task_event_pkg;

	typedef enum logic [1:0]
	{
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0]
	{
		RD_IDLE = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

	typedef logic [4:0] slot_t;

endpackage

// ==== rtl/event_flag_bank.sv ====
`timescale 1ns/1ps
module event_flag_bank
	import radio_task_event_pkg::*;
#(
	parameter int N = 12
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [N-1:0] set_pulse,
	input wire logic [N-1:0] clear_mask,
	output logic [N-1:0] flags_q
);

	// A set in the same cycle as a clear is kept, so no event is lost.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_q <= '0;
		else if (ce)
			flags_q <= (flags_q & ~clear_mask) | set_pulse; // [R15]
	end

endmodule

// ==== rtl/task_strobe.sv ====
`timescale 1ns/1ps
module task_strobe
	import radio_task_event_pkg::*;
#(
	parameter int N = 2
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [N-1:0] fire,
	output logic [N-1:0] pulse_q
);

	// Each trigger leaves as a single registered cycle toward the datapath.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pulse_q <= '0;
		else if (ce)
			pulse_q <= fire;
	end

endmodule

// ==== verif/radio_task_event_regs_tb.sv ====
`timescale 1ns/1ps
module radio_task_event_regs_tb
	import radio_task_event_pkg::*;
;
	// ****************************************
	// Bench signals and the block under test
	// ****************************************
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic ce = 1'b1;
	// Holding both answer readies high is legal and avoids re-driving them within one time step.
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, cca_begin_pulse, cca_halt_pulse;
	logic [1:0] bresp, rresp, got_resp;
	logic [31:0] rdata, got_data;
	logic [11:0] ev = 12'h000;
	int mismatches = 0;
	int total_checks = 0;
	int begin_cnt = 0;
	int halt_cnt = 0;
	logic [11:0] flag_addr [12] = '{12'h100, 12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118, 12'h11C,
		12'h128, 12'h130, 12'h134, 12'h138};

	radio_task_event_regs radio_task_event_regs_inst (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ev_ramp_done(ev[0]), .ev_address_seen(ev[1]), .ev_payload_done(ev[2]),
		.ev_packet_end(ev[3]), .ev_radio_off(ev[4]), .ev_device_hit(ev[5]), .ev_device_miss(ev[6]),
		.ev_strength_done(ev[7]), .ev_bit_count_hit(ev[8]), .ev_checksum_good(ev[9]),
		.ev_checksum_bad(ev[10]), .ev_frame_length(ev[11]), .cca_begin_pulse(cca_begin_pulse),
		.cca_halt_pulse(cca_halt_pulse));

	initial forever #25 aclk = ~aclk;

	// Counting at the falling edge sees each strobe once; a strobe held two cycles counts twice.
	always @(negedge aclk)
	begin
		if (cca_begin_pulse === 1'b1)
			begin_cnt++;
		if (cca_halt_pulse === 1'b1)
			halt_cnt++;
	end

	// ****************************************
	// Verdict, comparisons and bus cycles
	// ****************************************
	task end_of_test;
		if (mismatches == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task check_resp(input logic [1:0] got, input logic [1:0] exp);
		check_word({30'h0, got}, {30'h0, exp});
	endtask

	task stall(input logic ok);
		if (ok !== 1'b1)
		begin
			mismatches++;
			end_of_test;
		end
	endtask

	task bus_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		i = 0;
		do
		begin
			@(negedge aclk);
			i++;
		end
		while (awready !== 1'b1 && i < 100);
		stall(awready);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		i = 0;
		do
		begin
			@(negedge aclk);
			i++;
		end
		while (bvalid !== 1'b1 && i < 100);
		stall(bvalid);
		got_resp = bresp;
		@(posedge aclk);
	endtask

	task bus_read(input logic [11:0] a);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		i = 0;
		do
		begin
			@(negedge aclk);
			i++;
		end
		while (arready !== 1'b1 && i < 100);
		stall(arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		i = 0;
		do
		begin
			@(negedge aclk);
			i++;
		end
		while (rvalid !== 1'b1 && i < 100);
		stall(rvalid);
		got_data = rdata;
		got_resp = rresp;
		@(posedge aclk);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		for (int i = 0; i < 12; i++)
		begin
			bus_read(flag_addr[i]);
			check_word(got_data, 32'h00000000);
		end
		bus_read(12'h030);
		check_word(got_data, 32'h00000000);
	endtask

	task t_flags;
		for (int i = 0; i < 12; i++)
		begin
			ev[i] <= 1'b1;
			@(posedge aclk);
			ev[i] <= 1'b0;
			@(posedge aclk);
			bus_read(flag_addr[i]);
			check_word(got_data, 32'h1);
			bus_write(flag_addr[i], 32'h00000000, 4'h0);
			bus_read(flag_addr[i]);
			check_word(got_data, 32'h00000001);
			bus_write(flag_addr[i], 32'h00000000, 4'hF);
			bus_read(flag_addr[i]);
			check_word(got_data, 32'h00000000);
		end
	endtask

	// The event is high only at the edge that takes the clearing write, so a clear that wins is seen.
	task t_set_wins;
		ev[3] <= 1'b1;
		fork
			bus_write(12'h10C, 32'h00000000, 4'hF);
			begin
				@(posedge aclk);
				ev[3] <= 1'b0;
			end
		join
		bus_read(12'h10C);
		check_word(got_data, 32'h00000001);
		bus_write(12'h10C, 32'h00000000, 4'hF);
		bus_read(12'h10C);
		check_word(got_data, 32'h00000000);
	endtask

	task t_triggers;
		int b0, h0;
		b0 = begin_cnt;
		h0 = halt_cnt;
		bus_write(12'h02C, 32'h00000001, 4'hF);
		check_resp(got_resp, 2'h0);
		check_word(begin_cnt - b0, 32'h00000001);
		check_word(halt_cnt - h0, 32'h00000000);
		bus_write(12'h030, 32'h00000001, 4'hF);
		check_word(begin_cnt - b0, 32'h00000001);
		check_word(halt_cnt - h0, 32'h00000001);
		bus_write(12'h02C, 32'h00000000, 4'hF);
		bus_write(12'h030, 32'h00000000, 4'hF);
		check_word(begin_cnt + halt_cnt - b0 - h0, 32'h00000002);
	endtask

	// An event offered while the enable is low must be lost.
	task t_freeze;
		ce <= 1'b0;
		ev[2] <= 1'b1;
		@(posedge aclk);
		ev[2] <= 1'b0;
		ce <= 1'b1;
		@(posedge aclk);
		bus_read(12'h108);
		check_word(got_data, 32'h0);
	endtask

	task t_midreset;
		ev[0] <= 1'b1;
		@(posedge aclk);
		ev[0] <= 1'b0;
		bus_read(12'h100);
		check_word(got_data, 32'h1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		bus_read(12'h100);
		check_word(got_data, 32'h0);
	endtask

	task t_unmapped;
		bus_write(12'h200, 32'h00000001, 4'hF);
		check_resp(got_resp, 2'h2);
		bus_read(12'h200);
		check_word(got_data, 32'h00000000);
		check_resp(got_resp, 2'h2);
	endtask

	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_flags;
		t_set_wins;
		t_triggers;
		t_freeze;
		t_midreset;
		t_unmapped;
		end_of_test;
	end
endmodule
